// ===== core/sdc_pkg.sv
package sdc_pkg;

  // ------------------------------------------------------------
  // register addresses
  // ------------------------------------------------------------
  localparam logic [7:0] ADDR_STATUS = 8'hd8;
  localparam logic [7:0] ADDR_MODE   = 8'hd1;
  localparam logic [7:0] ADDR_EXCITE = 8'hd5;
  localparam logic [7:0] ADDR_PRES0  = 8'hd9; // low, then +1 mid, +2 high
  localparam logic [7:0] ADDR_POFF0  = 8'he1;
  localparam logic [7:0] ADDR_PGAIN0 = 8'he4;
  localparam logic [7:0] ADDR_ARES0  = 8'hdc;
  localparam logic [7:0] ADDR_AOFF0  = 8'he9;
  localparam logic [7:0] ADDR_AGAIN0 = 8'heb;

  // ------------------------------------------------------------
  // reset values and field positions
  // ------------------------------------------------------------
  localparam logic [7:0] STATUS_RST = 8'h00;
  localparam logic [7:0] MODE_RST   = 8'h08;
  localparam logic [7:0] EXCITE_RST = 8'h00;
  localparam logic [7:0] MODE_MASK  = 8'h7f; // bit 7 not built
  localparam logic [7:0] EXC_MASK   = 8'h0f; // low four bits only
  localparam int BIT_PRDY  = 7;
  localparam int BIT_ARDY  = 6;
  localparam int BIT_CAL   = 5;
  localparam int BIT_NOREF = 4;
  localparam int BIT_PERR  = 3;
  localparam int BIT_AERR  = 2;
  localparam int BIT_PEN   = 5;
  localparam int BIT_AEN   = 4;
  localparam int OPS_HI    = 2;
  localparam int OPS_LO    = 0;
  localparam int OPS_CAL   = 2; // op field msb marks a calibration
  localparam int OPS_FULL  = 0; // op field lsb: zero- or full-scale

  // op_select_field codes
  typedef enum logic [2:0] {
    SDC_OP_IDLE     = 3'h0,
    SDC_OP_CAL_IZS  = 3'h4,
    SDC_OP_CAL_IFS  = 3'h5,
    SDC_OP_CAL_SZS  = 3'h6,
    SDC_OP_CAL_SFS  = 3'h7
  } sdc_op_t;

  // widths
  localparam int FULL_BITS = 24;
  localparam int AUX_CBITS = 16;
  localparam int BYTE_BITS = 8;
  localparam int NCONV     = 2;

  // ------------------------------------------------------------
  // carriers
  // ------------------------------------------------------------
  // one finished filter word from a modulator; value is the scaled
  // input as a signed fraction of 2^N, may lie out of range
  typedef struct packed {
    logic                done;
    logic                cal_fault;
    logic signed [24:0]  value;
  } sdc_conv_in_t;

  // register bus request
  typedef struct packed {
    logic       wr;
    logic       bit_wr;
    logic [2:0] bit_sel;
    logic [7:0] addr;
    logic [7:0] wdata;
  } sdc_sfr_req_t;

endpackage : sdc_pkg

// ===== core/sdc_ref_sync.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// reference detect synchroniser
// ------------------------------------------------------------
module sdc_ref_sync (
  input  wire logic clk_i,
  input  wire logic nrst_i,
  input  wire logic async_i,
  output logic      level_o
);

  logic s1_reg;
  logic s2_reg;
  logic s3_reg;

  // three stages; level moves only when stages two and three agree
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      s1_reg  <= 1'b0;
      s2_reg  <= 1'b0;
      s3_reg  <= 1'b0;
      level_o <= 1'b0;
    end else begin
      s1_reg <= async_i;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      if (s2_reg == s3_reg) begin
        level_o <= s3_reg;
      end
    end
  end

endmodule : sdc_ref_sync

// ===== core/sdc_coder.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// result coder: straight or offset binary with clamping
// ------------------------------------------------------------
module sdc_coder #(
  parameter int N = 24
) (
  input  wire logic signed [N:0] value_i,
  input  wire logic              bipolar_i,
  input  wire logic              noref_i,
  output logic        [N-1:0]    code_o,
  output logic                   clamp_o
);

  localparam logic signed [N+1:0] TOP = (N+2)'(1) <<< N;
  localparam logic signed [N+1:0] MID = (N+2)'(1) <<< (N-1);

  logic signed [N+1:0] v;

  always_comb begin
    v = bipolar_i ? (N+2)'(value_i) + MID : (N+2)'(value_i);
    clamp_o = 1'b0;
    code_o = v[N-1:0];
    if (v < 0) begin
      code_o  = '0;
      clamp_o = 1'b1;
    end else if (v >= TOP) begin
      code_o  = '1;
      clamp_o = 1'b1;
    end
    if (noref_i) begin
      code_o  = '1;
      clamp_o = 1'b0;
    end
  end

endmodule : sdc_coder

// ===== core/sdc_status.sv
`timescale 1ns/1ps
module sdc_status #(
  parameter int PRI_BITS = 24,
  parameter bit DUAL     = 1'b1
) (
  input  wire logic                 clk_i,
  input  wire logic                 nrst_i,
  input  wire sdc_pkg::sdc_sfr_req_t sfr_req_i,
  input  wire sdc_pkg::sdc_conv_in_t pri_in_i,
  input  wire sdc_pkg::sdc_conv_in_t aux_in_i,
  input  wire logic                 pri_bipolar_i,
  input  wire logic                 aux_bipolar_i,
  input  wire logic                 aux_temp_sel_i,
  input  wire logic                 ref_bad_i,
  output logic [7:0]                sfr_rdata_o,
  output logic [7:0]                status_o,
  output logic                      pri_enable_o,
  output logic                      aux_enable_o,
  output logic [2:0]                op_select_o,
  output logic [1:0]                cal_start_o,
  output logic [3:0]                excite_route_o
);

  localparam int FB = sdc_pkg::FULL_BITS;
  localparam int AB = sdc_pkg::AUX_CBITS;
  localparam int BB = sdc_pkg::BYTE_BITS;

  // ------------------------------------------------------------
  // register state
  // ------------------------------------------------------------
  logic [7:0]    mode_reg;
  logic [7:0]    excite_reg;
  logic [1:0]    rdy_reg;
  logic [1:0]    err_reg;
  logic          cal_reg;
  logic          noref_reg;
  logic [1:0]    cal_pend_reg;
  logic [1:0]    cal_full_reg;
  logic [FB-1:0] pres_reg;
  logic [FB-1:0] ares_reg;
  logic [FB-1:0] poff_reg;
  logic [FB-1:0] pgain_reg;
  logic [AB-1:0] aoff_reg;
  logic [AB-1:0] again_reg;

  logic          ref_bad_s;
  logic          mode_wr;
  logic          stat_wr;
  logic [7:0]    stat_wval;
  logic          cal_req;
  logic [1:0]    wr_en;
  logic [7:0]    stat_cur;
  logic [1:0]    en;
  logic [1:0]    acc;
  logic [1:0]    abort;
  logic [1:0]    clamp;
  logic [PRI_BITS-1:0] pcode;
  logic [FB-1:0] acode;
  logic [FB-1:0] pcode_w;
  logic [7:0]    rd_next;

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  // byte n of a word
  function automatic logic [7:0] byte_of(input logic [FB-1:0] w,
                                         input int            n);
    byte_of = w[n*BB +: BB];
  endfunction : byte_of

  // offset of addr from a base, or 3 when outside [base, base+cnt)
  function automatic logic [1:0] idx_of(input logic [7:0] a,
                                        input logic [7:0] base,
                                        input int         cnt);
    logic [7:0] d;
    d = a - base;
    idx_of = (a >= base && d < 8'(cnt)) ? d[1:0] : 2'd3;
  endfunction : idx_of

  // ------------------------------------------------------------
  // reference detect and coders
  // ------------------------------------------------------------
  sdc_ref_sync u_ref (
    .clk_i   (clk_i),
    .nrst_i  (nrst_i),
    .async_i (ref_bad_i),
    .level_o (ref_bad_s)
  );

  sdc_coder #(.N(PRI_BITS)) u_pcode (
    .value_i   (pri_in_i.value[PRI_BITS:0]),
    .bipolar_i (pri_bipolar_i),
    .noref_i   (noref_reg),
    .code_o    (pcode),
    .clamp_o   (clamp[0])
  );

  sdc_coder #(.N(FB)) u_acode (
    .value_i   (aux_in_i.value),
    .bipolar_i (aux_bipolar_i),
    .noref_i   (noref_reg),
    .code_o    (acode),
    .clamp_o   (clamp[1])
  );

  // 16-bit word sits in mid and high bytes
  assign pcode_w = FB'(pcode) << (FB - PRI_BITS);

  // live flag byte; the registered copy lags by a cycle, so a bit
  // write built from it would drop a flag set the cycle before
  assign stat_cur = {rdy_reg[0], rdy_reg[1], cal_reg, noref_reg,
                     err_reg[0], err_reg[1], 2'b00};

  // ------------------------------------------------------------
  // decode
  // ------------------------------------------------------------
  // a bit write to the status byte is a read-modify-write
  always_comb begin
    mode_wr   = sfr_req_i.wr && sfr_req_i.addr == sdc_pkg::ADDR_MODE;
    stat_wr   = sfr_req_i.addr == sdc_pkg::ADDR_STATUS &&
                (sfr_req_i.wr || sfr_req_i.bit_wr);
    stat_wval = sfr_req_i.wdata;
    if (sfr_req_i.bit_wr) begin
      stat_wval = stat_cur;
      stat_wval[sfr_req_i.bit_sel] = sfr_req_i.wdata[0];
    end
    cal_req = mode_wr && sfr_req_i.wdata[sdc_pkg::OPS_CAL];
    // enables carried by the value being written, not the old mode
    wr_en   = {sfr_req_i.wdata[sdc_pkg::BIT_AEN] & DUAL,
               sfr_req_i.wdata[sdc_pkg::BIT_PEN]};
  end

  assign en = {mode_reg[sdc_pkg::BIT_AEN] & DUAL,
               mode_reg[sdc_pkg::BIT_PEN]};

  // word accepted only while ready is low
  always_comb begin
    acc[0] = pri_in_i.done && !rdy_reg[0];
    acc[1] = DUAL && aux_in_i.done && !rdy_reg[1] &&
             !(cal_pend_reg[1] && aux_temp_sel_i);
    abort  = cal_pend_reg & {2{noref_reg}};
  end

  // ------------------------------------------------------------
  // mode and excitation registers
  // ------------------------------------------------------------
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      mode_reg   <= sdc_pkg::MODE_RST;
      excite_reg <= sdc_pkg::EXCITE_RST;
    end else if (sfr_req_i.wr) begin
      if (sfr_req_i.addr == sdc_pkg::ADDR_MODE) begin
        mode_reg <= sfr_req_i.wdata & sdc_pkg::MODE_MASK;
      end
      if (sfr_req_i.addr == sdc_pkg::ADDR_EXCITE) begin
        excite_reg <= sfr_req_i.wdata & sdc_pkg::EXC_MASK;
      end
    end
  end

  // outputs to the analog side, all registered
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pri_enable_o   <= 1'b0;
      aux_enable_o   <= 1'b0;
      op_select_o    <= sdc_pkg::SDC_OP_IDLE;
      cal_start_o    <= 2'b00;
      excite_route_o <= 4'h0;
    end else begin
      pri_enable_o   <= en[0];
      aux_enable_o   <= en[1];
      op_select_o    <= mode_reg[sdc_pkg::OPS_HI:sdc_pkg::OPS_LO];
      excite_route_o <= excite_reg[3:0];
      cal_start_o    <= cal_req ? wr_en : 2'b00;
    end
  end

  // ------------------------------------------------------------
  // missing reference flag
  // ------------------------------------------------------------
  // valid only while active
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      noref_reg <= 1'b0;
    end else begin
      noref_reg <= ref_bad_s && (en != 2'b00);
    end
  end

  // ------------------------------------------------------------
  // calibration bookkeeping
  // ------------------------------------------------------------
  // a calibration is tracked per converter from the mode write
  // until its word arrives or the reference drops
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cal_pend_reg <= 2'b00;
      cal_full_reg <= 2'b00;
    end else begin
      for (int c = 0; c < sdc_pkg::NCONV; c++) begin
        if (acc[c] || abort[c]) begin
          cal_pend_reg[c] <= 1'b0;
        end
      end
      if (mode_wr) begin
        cal_pend_reg <= cal_req ? wr_en : 2'b00;
        cal_full_reg <= {2{sfr_req_i.wdata[sdc_pkg::OPS_FULL]}};
      end
    end
  end

  // ------------------------------------------------------------
  // ready flags
  // ------------------------------------------------------------
  // hardware set wins over any clear in the same cycle
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rdy_reg <= 2'b00;
    end else begin
      for (int c = 0; c < sdc_pkg::NCONV; c++) begin
        if (stat_wr && !stat_wval[sdc_pkg::BIT_PRDY - c]) begin
          rdy_reg[c] <= 1'b0;
        end
        if (cal_req) begin
          rdy_reg[c] <= 1'b0;
        end
        if (acc[c] && !abort[c]) begin
          rdy_reg[c] <= 1'b1;
        end
      end
    end
  end

  // ------------------------------------------------------------
  // calibration-done and error flags
  // ------------------------------------------------------------
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cal_reg <= 1'b0;
      err_reg <= 2'b00;
    end else begin
      if (mode_wr) begin
        cal_reg <= 1'b0;
        err_reg <= 2'b00;
      end
      for (int c = 0; c < sdc_pkg::NCONV; c++) begin
        if (abort[c]) begin
          err_reg[c] <= 1'b1;
        end else if (acc[c]) begin
          if (cal_pend_reg[c]) begin
            cal_reg <= 1'b1;
            if (c == 0 ? pri_in_i.cal_fault : aux_in_i.cal_fault) begin
              err_reg[c] <= 1'b1;
            end
          end else if (clamp[c]) begin
            err_reg[c] <= 1'b1;
          end
        end
      end
    end
  end

  // ------------------------------------------------------------
  // result and coefficient registers
  // ------------------------------------------------------------
  // software may also load coefficients; a hardware update in the
  // same cycle takes precedence
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pres_reg  <= '0;
      ares_reg  <= '0;
      poff_reg  <= '0;
      pgain_reg <= '0;
      aoff_reg  <= '0;
      again_reg <= '0;
    end else begin
      if (sfr_req_i.wr) begin
        for (int b = 0; b < 3; b++) begin
          if (idx_of(sfr_req_i.addr, sdc_pkg::ADDR_POFF0, 3) == b) begin
            poff_reg[b*BB +: BB] <= sfr_req_i.wdata;
          end
          if (idx_of(sfr_req_i.addr, sdc_pkg::ADDR_PGAIN0, 3) == b) begin
            pgain_reg[b*BB +: BB] <= sfr_req_i.wdata;
          end
        end
        for (int b = 0; b < 2; b++) begin
          if (idx_of(sfr_req_i.addr, sdc_pkg::ADDR_AOFF0, 2) == b) begin
            aoff_reg[b*BB +: BB] <= sfr_req_i.wdata;
          end
          if (idx_of(sfr_req_i.addr, sdc_pkg::ADDR_AGAIN0, 2) == b) begin
            again_reg[b*BB +: BB] <= sfr_req_i.wdata;
          end
        end
      end
      if (acc[0] && !abort[0]) begin
        if (!cal_pend_reg[0]) begin
          pres_reg <= pcode_w;
        end else if (!pri_in_i.cal_fault) begin
          if (cal_full_reg[0]) begin
            pgain_reg <= pcode_w;
          end else begin
            poff_reg <= pcode_w;
          end
        end
      end
      if (acc[1] && !abort[1]) begin
        if (!cal_pend_reg[1]) begin
          ares_reg <= acode;
        end else if (!aux_in_i.cal_fault) begin
          if (cal_full_reg[1]) begin
            again_reg <= acode[FB-1 -: AB];
          end else begin
            aoff_reg <= acode[FB-1 -: AB];
          end
        end
      end
    end
  end

  // ------------------------------------------------------------
  // status view and read port
  // ------------------------------------------------------------
  // low two bits zero
  always_comb begin
    rd_next = 8'h00;
    case (idx_of(sfr_req_i.addr, sdc_pkg::ADDR_PRES0, 3))
      2'd0:    rd_next = (PRI_BITS < FB) ? 8'h00 : byte_of(pres_reg, 0);
      2'd1:    rd_next = byte_of(pres_reg, 1);
      2'd2:    rd_next = byte_of(pres_reg, 2);
      default: rd_next = 8'h00;
    endcase
    for (int b = 0; b < 3; b++) begin
      if (idx_of(sfr_req_i.addr, sdc_pkg::ADDR_POFF0, 3) == b) begin
        rd_next = (b == 0 && PRI_BITS < FB) ? 8'h00 : byte_of(poff_reg, b);
      end
      if (idx_of(sfr_req_i.addr, sdc_pkg::ADDR_PGAIN0, 3) == b) begin
        rd_next = (b == 0 && PRI_BITS < FB) ? 8'h00 : byte_of(pgain_reg, b);
      end
      if (DUAL && idx_of(sfr_req_i.addr, sdc_pkg::ADDR_ARES0, 3) == b) begin
        rd_next = byte_of(ares_reg, b);
      end
      if (DUAL && idx_of(sfr_req_i.addr, sdc_pkg::ADDR_AOFF0, 2) == b) begin
        rd_next = byte_of(FB'(aoff_reg), b);
      end
      if (DUAL && idx_of(sfr_req_i.addr, sdc_pkg::ADDR_AGAIN0, 2) == b) begin
        rd_next = byte_of(FB'(again_reg), b);
      end
    end
    if (sfr_req_i.addr == sdc_pkg::ADDR_STATUS) begin
      rd_next = stat_cur;
    end
    if (sfr_req_i.addr == sdc_pkg::ADDR_MODE) begin
      rd_next = mode_reg;
    end
    if (sfr_req_i.addr == sdc_pkg::ADDR_EXCITE) begin
      rd_next = excite_reg;
    end
  end

  // read data lags the address by one clock
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sfr_rdata_o <= 8'h00;
      status_o    <= sdc_pkg::STATUS_RST;
    end else begin
      sfr_rdata_o <= rd_next;
      status_o    <= stat_cur;
    end
  end

endmodule : sdc_status

// ===== sim/sdc_status_checker.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// port-level checks for the status block
// ------------------------------------------------------------
module sdc_status_checker #(
  parameter int PRI_BITS = 24,
  parameter bit DUAL     = 1'b1
) (
  input wire logic                  clk_i,
  input wire logic                  nrst_i,
  input wire sdc_pkg::sdc_sfr_req_t sfr_req_i,
  input wire sdc_pkg::sdc_conv_in_t pri_in_i,
  input wire sdc_pkg::sdc_conv_in_t aux_in_i,
  input wire logic                  pri_bipolar_i,
  input wire logic                  aux_bipolar_i,
  input wire logic                  aux_temp_sel_i,
  input wire logic                  ref_bad_i,
  input wire logic [7:0]            sfr_rdata_o,
  input wire logic [7:0]            status_o,
  input wire logic                  pri_enable_o,
  input wire logic                  aux_enable_o,
  input wire logic [2:0]            op_select_o,
  input wire logic [1:0]            cal_start_o,
  input wire logic [3:0]            excite_route_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  // write decodes; a done in the same cycle may re-set flags
  logic mw, ew, sw, dn;
  assign mw = sfr_req_i.wr && sfr_req_i.addr == sdc_pkg::ADDR_MODE;
  assign ew = sfr_req_i.wr && sfr_req_i.addr == sdc_pkg::ADDR_EXCITE;
  assign sw = sfr_req_i.wr && sfr_req_i.addr == sdc_pkg::ADDR_STATUS;
  assign dn = pri_in_i.done || aux_in_i.done;
  property p_cal_start;
    logic [7:0] d;
    (mw, d = sfr_req_i.wdata) |=>
      cal_start_o == ({d[4] & DUAL, d[5]} & {2{d[2]}});
  endproperty
  a_cal_start: assert property (p_cal_start)
    else $error("cal start pulse wrong");
  property p_excite;
    logic [7:0] d;
    (ew, d = sfr_req_i.wdata) |-> ##2 excite_route_o == d[3:0];
  endproperty
  a_excite: assert property (p_excite)
    else $error("excitation route wrong");
  property p_unused;
    status_o[1:0] == 2'b00;
  endproperty
  a_unused: assert property (p_unused)
    else $error("unbuilt status bits set");
  property p_mode_clr;
    mw && !dn |-> ##2 (status_o & 8'h2c) == 8'h00;
  endproperty
  a_mode_clr: assert property (p_mode_clr)
    else $error("mode write left flags set");
  property p_sw_clr;
    sw && !sfr_req_i.wdata[7] && !pri_in_i.done |-> ##2 !status_o[7];
  endproperty
  a_sw_clr: assert property (p_sw_clr)
    else $error("ready not cleared");
  property p_rdy_set;
    pri_in_i.done |-> ##[1:2] status_o[7];
  endproperty
  a_rdy_set: assert property (p_rdy_set)
    else $error("ready not set");
  property p_nref_on;
    (ref_bad_i && pri_enable_o) [*8] |-> status_o[4];
  endproperty
  a_nref_on: assert property (p_nref_on)
    else $error("missing reference not flagged");
  property p_nref_off;
    (!ref_bad_i) [*8] |-> !status_o[4];
  endproperty
  a_nref_off: assert property (p_nref_off)
    else $error("reference flag stuck");
endmodule : sdc_status_checker

bind sdc_status sdc_status_checker #(
  .PRI_BITS(PRI_BITS), .DUAL(DUAL)
) sdc_status_checker_inst (
  .clk_i(clk_i), .nrst_i(nrst_i), .sfr_req_i(sfr_req_i),
  .pri_in_i(pri_in_i), .aux_in_i(aux_in_i),
  .pri_bipolar_i(pri_bipolar_i), .aux_bipolar_i(aux_bipolar_i),
  .aux_temp_sel_i(aux_temp_sel_i), .ref_bad_i(ref_bad_i),
  .sfr_rdata_o(sfr_rdata_o), .status_o(status_o),
  .pri_enable_o(pri_enable_o), .aux_enable_o(aux_enable_o),
  .op_select_o(op_select_o), .cal_start_o(cal_start_o),
  .excite_route_o(excite_route_o)
);

// ===== sim/sdc_mod_model.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// modulator stand-in: one-cycle finished words
// ------------------------------------------------------------
module sdc_mod_model (
  input  wire logic            clk_i,
  output sdc_pkg::sdc_conv_in_t pri_o,
  output sdc_pkg::sdc_conv_in_t aux_o
);
  initial begin
    pri_o = '0;
    aux_o = '0;
  end
  // value is scrambled between words so stale data never matches
  task automatic word(input logic a, input logic f,
                      input logic signed [24:0] v);
    sdc_pkg::sdc_conv_in_t w;
    w = '{done: 1'b1, cal_fault: f, value: v};
    @(negedge clk_i);
    if (a) aux_o = w; else pri_o = w;
    @(negedge clk_i);
    w = '{done: 1'b0, cal_fault: ~f, value: ~v};
    if (a) aux_o = w; else pri_o = w;
  endtask : word
endmodule : sdc_mod_model

// ===== sim/sdc_status_tb.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// register-level scenarios
// ------------------------------------------------------------
module sdc_status_tb;
  localparam logic [7:0] ST = sdc_pkg::ADDR_STATUS;
  localparam logic [7:0] MD = sdc_pkg::ADDR_MODE;
  localparam logic [7:0] EX = sdc_pkg::ADDR_EXCITE;
  localparam logic [7:0] PR = sdc_pkg::ADDR_PRES0;
  localparam logic [7:0] PO = sdc_pkg::ADDR_POFF0;
  logic                  clk_i, nrst_i, pbip, abip, tsel, rbad;
  sdc_pkg::sdc_sfr_req_t req;
  sdc_pkg::sdc_conv_in_t pin, ain;
  logic [7:0]            rdata, status;
  logic                  pen, aen;
  logic [2:0]            ops;
  logic [1:0]            cst;
  logic [3:0]            exc;
  int                    failures, total_checks;
  sdc_mod_model sdc_mod_model_inst (.clk_i(clk_i), .pri_o(pin),
    .aux_o(ain));
  sdc_status sdc_status_inst (.clk_i(clk_i), .nrst_i(nrst_i),
    .sfr_req_i(req), .pri_in_i(pin), .aux_in_i(ain),
    .pri_bipolar_i(pbip), .aux_bipolar_i(abip),
    .aux_temp_sel_i(tsel), .ref_bad_i(rbad), .sfr_rdata_o(rdata),
    .status_o(status), .pri_enable_o(pen), .aux_enable_o(aen),
    .op_select_o(ops), .cal_start_o(cst), .excite_route_o(exc));
  // 25 ns core clock
  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end
  task automatic wrap_up();
    if (failures == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : wrap_up
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    total_checks++;
    if (g !== e) begin
      failures++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  // strobe held for exactly one edge, dropped at the next fall
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_i);
    req = '{wr: 1'b1, bit_wr: 1'b0, bit_sel: 3'h0, addr: a, wdata: d};
    @(negedge clk_i);
    req.wr = 1'b0;
  endtask : wr
  task automatic bw(input logic [2:0] b, input logic v);
    @(negedge clk_i);
    req = '{wr: 1'b0, bit_wr: 1'b1, bit_sel: b, addr: ST,
            wdata: {7'h00, v}};
    @(negedge clk_i);
    req.bit_wr = 1'b0;
  endtask : bw
  // read data is registered, so look one cycle after the address
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(negedge clk_i);
    req.addr = a;
    @(negedge clk_i);
    chk(rdata, e);
  endtask : rd
  task automatic rd3(input logic [7:0] a, input logic [23:0] e);
    for (int i = 0; i < 3; i++) begin
      rd(a + 8'(i), e[8*i +: 8]);
    end
  endtask : rd3
  task automatic wd(input logic a, input logic signed [24:0] v);
    sdc_mod_model_inst.word(a, 1'b0, v);
  endtask : wd
  // hang guard
  initial begin
    repeat (60000) @(posedge clk_i);
    failures++;
    wrap_up();
  end
  initial begin
    {nrst_i, pbip, abip, tsel, rbad} = '0;
    req = '0;
    repeat (10) @(negedge clk_i);
    nrst_i = 1'b1;
    repeat (20000) @(negedge clk_i);
    rd(ST, 8'h00);
    rd(MD, 8'h08);
    wr(EX, 8'hff);
    rd(EX, 8'h0f);
    chk({4'h0, exc}, 8'h0f);
    wr(MD, 8'h24);
    wd(1'b0, 25'h012_3456);
    rd(ST, 8'ha0);
    rd3(PO, 24'h12_3456);
    wd(1'b0, 25'h000_0001);
    rd3(PO, 24'h12_3456);
    bw(3'h5, 1'b1);
    bw(3'h7, 1'b1);
    rd(ST, 8'ha0);
    bw(3'h7, 1'b0);
    rd(ST, 8'h20);
    wr(MD, 8'h20);
    rd(ST, 8'h00);
    wd(1'b0, 25'h0ab_cdef);
    rd(ST, 8'h80);
    rd3(PR, 24'hab_cdef);
    wr(ST, 8'h00);
    pbip = 1'b1;
    wd(1'b0, 25'h0ff_ffff);
    pbip = 1'b0;
    rd(ST, 8'h88);
    rd3(PR, 24'hff_ffff);
    wr(MD, 8'h20);
    rd(ST, 8'h80);
    wr(ST, 8'h00);
    wd(1'b0, -25'sd1);
    rd3(PR, 24'h00_0000);
    pbip = 1'b1;
    wr(ST, 8'h00);
    wd(1'b0, 25'h000_0000);
    rd3(PR, 24'h80_0000);
    pbip = 1'b0;
    wr(MD, 8'h20);
    wr(ST, 8'h00);
    rbad = 1'b1;
    repeat (8) @(negedge clk_i);
    rd(ST, 8'h10);
    wd(1'b0, 25'h000_0010);
    rd3(PR, 24'hff_ffff);
    rbad = 1'b0;
    repeat (8) @(negedge clk_i);
    rd(ST, 8'h80);
    tsel = 1'b1;
    wr(MD, 8'h14);
    wd(1'b1, 25'h000_1234);
    rd(ST, 8'h00);
    chk({2'b00, pen, aen, 1'b0, ops}, 8'h14);
    tsel = 1'b0;
    wd(1'b1, 25'h000_1234);
    rd(ST, 8'h60);
    rd(sdc_pkg::ADDR_AOFF0, 8'h12);
    wrap_up();
  end
endmodule : sdc_status_tb
